/* verilog/sram_boundary_scan_tap.sv */
// Boundary-scan test access port of the memory device.
`default_nettype none
module sram_boundary_scan_tap #(
	parameter logic [2:0]  OpExtest  = scan_tap_pkg::OpExtest,
	parameter logic [2:0]  OpIdcode  = scan_tap_pkg::OpIdcode,
	parameter logic [2:0]  OpSampleZ = scan_tap_pkg::OpSampleZ,
	parameter logic [2:0]  OpSample  = scan_tap_pkg::OpSample,
	parameter logic [2:0]  OpBypass  = scan_tap_pkg::OpBypass,
	// Identification code value is arbitrary.
	parameter logic [31:0] IdCode    = 32'h0000_0001,
	parameter int          BsrWidth  = scan_tap_pkg::BsrWidth
) (
	// Clock and power-up reset
	input  wire logic                clk,
	input  wire logic                reset_n,
	// Test pins
	input  wire logic                tck,
	input  wire logic                tms,
	input  wire logic                tdi,
	output logic                     tdo,
	output logic                     tdoOe,
	// Pin ring
	input  wire logic [BsrWidth-1:0] pinValues,
	output logic [BsrWidth-1:0]      pinDrive,
	output logic                     extestActive,
	output logic                     readBusOe
);
	logic                  tmsS;
	logic                  tdiS;
	logic                  rise;
	logic                  fall;
	scan_tap_pkg::tap_state_t state_q;
	scan_tap_pkg::tap_state_t state_d;
	logic [2:0]            irShift_q;
	logic [2:0]            instr_q;
	logic                  bypass_q;
	logic [31:0]           idShift_q;
	logic [BsrWidth-1:0]   bsrShift_q;
	logic [BsrWidth-1:0]   bsrLatch_q;
	logic                  serialBit;
	logic                  tdo_q;
	logic                  tdoOe_q;
	logic                  selBsr;
	logic                  selId;

	tck_sampler sampler (
		.clk     (clk),
		.reset_n (reset_n),
		.tckPin  (tck),
		.tmsPin  (tms),
		.tdiPin  (tdi),
		.tmsSync (tmsS),
		.tdiSync (tdiS),
		.tckRise (rise),
		.tckFall (fall)
	);

	// Controller next state; five high samples reach reset from anywhere.
	always_comb begin
		state_d = state_q;
		case (state_q)
			scan_tap_pkg::TestReset:
				state_d = tmsS ? scan_tap_pkg::TestReset
				               : scan_tap_pkg::RunIdle;
			scan_tap_pkg::RunIdle:
				state_d = tmsS ? scan_tap_pkg::SelDr : scan_tap_pkg::RunIdle;
			scan_tap_pkg::SelDr:
				state_d = tmsS ? scan_tap_pkg::SelIr : scan_tap_pkg::CapDr;
			scan_tap_pkg::CapDr:
				state_d = tmsS ? scan_tap_pkg::Ex1Dr : scan_tap_pkg::ShDr;
			scan_tap_pkg::ShDr:
				state_d = tmsS ? scan_tap_pkg::Ex1Dr : scan_tap_pkg::ShDr;
			scan_tap_pkg::Ex1Dr:
				state_d = tmsS ? scan_tap_pkg::UpdDr : scan_tap_pkg::PauseDr;
			scan_tap_pkg::PauseDr:
				state_d = tmsS ? scan_tap_pkg::Ex2Dr : scan_tap_pkg::PauseDr;
			scan_tap_pkg::Ex2Dr:
				state_d = tmsS ? scan_tap_pkg::UpdDr : scan_tap_pkg::ShDr;
			scan_tap_pkg::UpdDr:
				state_d = tmsS ? scan_tap_pkg::SelDr : scan_tap_pkg::RunIdle;
			scan_tap_pkg::SelIr:
				state_d = tmsS ? scan_tap_pkg::TestReset
				               : scan_tap_pkg::CapIr;
			scan_tap_pkg::CapIr:
				state_d = tmsS ? scan_tap_pkg::Ex1Ir : scan_tap_pkg::ShIr;
			scan_tap_pkg::ShIr:
				state_d = tmsS ? scan_tap_pkg::Ex1Ir : scan_tap_pkg::ShIr;
			scan_tap_pkg::Ex1Ir:
				state_d = tmsS ? scan_tap_pkg::UpdIr : scan_tap_pkg::PauseIr;
			scan_tap_pkg::PauseIr:
				state_d = tmsS ? scan_tap_pkg::Ex2Ir : scan_tap_pkg::PauseIr;
			scan_tap_pkg::Ex2Ir:
				state_d = tmsS ? scan_tap_pkg::UpdIr : scan_tap_pkg::ShIr;
			scan_tap_pkg::UpdIr:
				state_d = tmsS ? scan_tap_pkg::SelDr : scan_tap_pkg::RunIdle;
			default:
				state_d = scan_tap_pkg::TestReset;
		endcase
	end

	// The port reset only touches test logic, so memory traffic runs on.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			state_q <= scan_tap_pkg::TestReset;
		end else if (rise) begin
			state_q <= state_d;
		end
	end

	// Instruction shift and update.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			irShift_q <= 3'h0;
			instr_q   <= OpIdcode;
		end else if (rise && state_d == scan_tap_pkg::TestReset) begin
			// Load on entry, so the reset instruction is live at once.
			instr_q <= OpIdcode;
		end else if (rise) begin
			case (state_q)
				scan_tap_pkg::TestReset: begin
					instr_q <= OpIdcode;
				end
				scan_tap_pkg::CapIr: begin
					irShift_q <= {1'b0, scan_tap_pkg::IrCapture};
				end
				scan_tap_pkg::ShIr: begin
					irShift_q <= {tdiS, irShift_q[2:1]};
				end
				scan_tap_pkg::UpdIr: begin
					instr_q <= irShift_q;
				end
				default: begin
					instr_q <= instr_q;
				end
			endcase
		end
	end

	// Reserved opcodes fall through to the bypass path.
	assign selBsr = (instr_q == OpExtest) || (instr_q == OpSample)
	              || (instr_q == OpSampleZ);
	assign selId  = (instr_q == OpIdcode);

	// Data registers; only the selected one captures and shifts.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			bypass_q   <= 1'b0;
			idShift_q  <= 32'h0;
			bsrShift_q <= '0;
		end else if (rise) begin
			if (state_q == scan_tap_pkg::CapDr) begin
				if (selBsr) begin
					bsrShift_q <= pinValues;
				end else if (selId) begin
					idShift_q <= IdCode;
				end else begin
					bypass_q <= 1'b0;
				end
			end else if (state_q == scan_tap_pkg::ShDr) begin
				if (selBsr) begin
					bsrShift_q <= {tdiS, bsrShift_q[BsrWidth-1:1]};
				end else if (selId) begin
					idShift_q <= {tdiS, idShift_q[31:1]};
				end else begin
					bypass_q <= tdiS;
				end
			end
		end
	end

	// Preload latch; the float cell presets high so reads drive by default.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			bsrLatch_q <= '0;
			bsrLatch_q[scan_tap_pkg::FloatCell] <= 1'b1;
		end else if (rise) begin
			if (state_d == scan_tap_pkg::TestReset) begin
				bsrLatch_q[scan_tap_pkg::FloatCell] <= 1'b1;
			end else if (state_q == scan_tap_pkg::UpdDr && selBsr) begin
				bsrLatch_q <= bsrShift_q;
			end
		end
	end

	// One source feeds the serial output at a time.
	always_comb begin
		case (state_q)
			scan_tap_pkg::ShIr: serialBit = irShift_q[0];
			default: begin
				if (selBsr) begin
					serialBit = bsrShift_q[0];
				end else if (selId) begin
					serialBit = idShift_q[0];
				end else begin
					serialBit = bypass_q;
				end
			end
		endcase
	end

	// Output moves on the falling edge, giving the far end a half period.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			tdo_q   <= 1'b1;
			tdoOe_q <= 1'b0;
		end else if (fall) begin
			tdo_q   <= serialBit;
			tdoOe_q <= (state_q == scan_tap_pkg::ShDr)
			        || (state_q == scan_tap_pkg::ShIr);
		end
	end

	assign tdo          = tdo_q;
	assign tdoOe        = tdoOe_q;
	assign pinDrive     = bsrLatch_q;
	assign extestActive = (instr_q == OpExtest);
	assign readBusOe    = (instr_q == OpSampleZ) ? 1'b0
	                    : extestActive
	                    ? bsrLatch_q[scan_tap_pkg::FloatCell]
	                    : 1'b1;
endmodule
`default_nettype wire

/* verilog/scan_tap_pkg.sv */
// Constants and types shared by the boundary-scan test port.
// How it works
// - All test inputs are sampled on the rising test clock edge.
// - Serial data out changes only on the falling test clock edge.
// - Controller moves on mode select sampled at each rising edge.
// - Loaded instruction picks the one register between data in and out.
// - Exactly one register sits in the serial path, never two chained.
// - Registers shift toward bit zero; input at top, output from bit zero.
// - Serial output driven only while shifting, floating otherwise.
// - Five high mode select samples return controller to reset.
// - Port reset leaves normal memory operation untouched.
// - Power up resets the controller so serial output floats.
// - Three-bit instruction register loads identify at power up and reset.
// - Instruction capture loads pattern 01 into the two low bits.
// - One-bit bypass register, cleared when bypass executes.
// - Data capture loads pin values into boundary register, then shifts.
// - Boundary chain includes cells for unconnected package positions.
// - Identify instruction captures and shifts the fixed 32-bit code.
// - Instruction bits shift through the instruction register in shift state.
// - New instruction applies only on passing the instruction update state.
// - Float-sample selects boundary register and floats read data bus.
// - Under external test, cell 108 enables read drivers; presets high.
// - External test drives preloaded values onto output pins.
// - Sample/preload snapshots pins while new preload shifts in.
`default_nettype none
package scan_tap_pkg;
	typedef enum {
		TestReset, RunIdle, SelDr, CapDr, ShDr, Ex1Dr, PauseDr, Ex2Dr,
		UpdDr, SelIr, CapIr, ShIr, Ex1Ir, PauseIr, Ex2Ir, UpdIr
	} tap_state_t;
	localparam int IrWidth    = 3;
	localparam int IdWidth    = 32;
	localparam int BsrWidth   = 109;
	localparam int FloatCell  = 108;
	localparam logic [1:0] IrCapture = 2'h1;
	localparam logic [2:0] OpExtest  = 3'h0;
	localparam logic [2:0] OpIdcode  = 3'h1;
	localparam logic [2:0] OpSampleZ = 3'h2;
	localparam logic [2:0] OpSample  = 3'h4;
	localparam logic [2:0] OpBypass  = 3'h7;
endpackage
`default_nettype wire

/* verilog/tck_sampler.sv */
// Two-stage synchroniser with rising and falling edge detect for the test clock.
`default_nettype none
module tck_sampler (
	// Clock and reset
	input  wire logic clk,
	input  wire logic reset_n,
	// Raw test pins
	input  wire logic tckPin,
	input  wire logic tmsPin,
	input  wire logic tdiPin,
	// Synchronised values and edge strobes
	output logic      tmsSync,
	output logic      tdiSync,
	output logic      tckRise,
	output logic      tckFall
);
	logic [1:0] tckMeta_q;
	logic [1:0] tmsMeta_q;
	logic [1:0] tdiMeta_q;
	logic       tckLast_q;

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			tckMeta_q <= 2'h0;
			tmsMeta_q <= 2'h3;
			tdiMeta_q <= 2'h3;
			tckLast_q <= 1'b0;
		end else begin
			tckMeta_q <= {tckMeta_q[0], tckPin};
			tmsMeta_q <= {tmsMeta_q[0], tmsPin};
			tdiMeta_q <= {tdiMeta_q[0], tdiPin};
			tckLast_q <= tckMeta_q[1];
		end
	end

	assign tmsSync = tmsMeta_q[1];
	assign tdiSync = tdiMeta_q[1];
	assign tckRise = tckMeta_q[1] & ~tckLast_q;
	assign tckFall = ~tckMeta_q[1] & tckLast_q;
endmodule
`default_nettype wire

/* tb/scan_host.sv */
// Behavioural board controller that drives the scan port pins.
`default_nettype none
module scan_host (
	// Clock
	input  wire logic clk,
	// Test pins
	output var logic  tck,
	output var logic  tms,
	output var logic  tdi,
	input  wire logic tdo,
	input  wire logic tdoOe
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b1;
	end
	// One 200 ns test clock period, entered on a clk edge.
	// The clock is parked low between calls, so it never runs free.
	task automatic step(input logic m, input logic v, output logic o,
		output logic oe);
		tms <= m;
		tdi <= v;
		repeat (4) @(posedge clk);
		// An undriven output is read as garbage, never as the last bit.
		o = tdoOe ? tdo : !tdo;
		oe = tdoOe;
		tck <= 1'b1;
		repeat (4) @(posedge clk);
		tck <= 1'b0;
	endtask
	// Five mode select highs reach reset from anywhere, then idle.
	task automatic reset5();
		logic o, oe;
		repeat (5) step(1'b1, 1'b1, o, oe);
		step(1'b0, 1'b1, o, oe);
	endtask
endmodule
`default_nettype wire

/* tb/sram_boundary_scan_tap_sva.sv */
// Checker for the scan port pins.
`default_nettype none
module sram_boundary_scan_tap_sva #(
	parameter int BsrWidth = scan_tap_pkg::BsrWidth
) (
	// Clock and reset
	input wire logic                clk,
	input wire logic                reset_n,
	// Test pins
	input wire logic                tck,
	input wire logic                tms,
	input wire logic                tdo,
	input wire logic                tdoOe,
	// Pin ring
	input wire logic [BsrWidth-1:0] pinDrive,
	input wire logic                extestActive,
	input wire logic                readBusOe
);
	logic       tckQ;
	logic [2:0] tmsRunQ;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	always_ff @(posedge clk) begin
		tckQ <= tck;
	end
	// Counts test clock rises seen with mode select high, held at five.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			tmsRunQ <= 3'h0;
		end else if (tck && !tckQ) begin
			tmsRunQ <= !tms ? 3'h0 : (tmsRunQ == 3'h5 ? 3'h5 : tmsRunQ + 3'h1);
		end
	end
	a_tdo_on_fall: assert property (
		$changed(tdo) |-> !tck && $past(tck, 4)) else $error("tdo off fall");
	a_oe_on_fall: assert property (
		$changed(tdoOe) |-> !tck && $past(tck, 4)) else $error("oe off fall");
	a_oe_needs_shift: assert property (
		$rose(tdoOe) |-> tmsRunQ == 3'h0) else $error("oe without shift");
	a_five_reset: assert property (
		tmsRunQ == 3'h5 && !tck |-> !tdoOe && !extestActive &&
		pinDrive[scan_tap_pkg::FloatCell]) else $error("no port reset");
	a_float_cell: assert property (
		extestActive |-> readBusOe == pinDrive[scan_tap_pkg::FloatCell])
		else $error("read bus enable wrong");
	a_drive_on_rise: assert property (
		$changed(pinDrive) |-> tck) else $error("latch off rise");
	a_instr_on_rise: assert property (
		$changed(extestActive) |-> tck) else $error("instr off rise");
	a_powerup_quiet: assert property (
		$rose(reset_n) |-> !tdoOe) else $error("tdo driven at power up");
endmodule
bind sram_boundary_scan_tap sram_boundary_scan_tap_sva #(.BsrWidth(BsrWidth))
	sva_inst (.clk(clk), .reset_n(reset_n), .tck(tck), .tms(tms), .tdo(tdo),
	.tdoOe(tdoOe), .pinDrive(pinDrive), .extestActive(extestActive),
	.readBusOe(readBusOe));
`default_nettype wire

/* tb/sram_boundary_scan_tap_tb.sv */
// Self-checking bench for the boundary-scan test port.
`default_nettype none
module sram_boundary_scan_tap_tb;
	timeunit 1ns;
	timeprecision 1ps;
	// Identification value is arbitrary.
	localparam logic [31:0] IdVal = 32'h5a3c_0e71;
	localparam int W = scan_tap_pkg::BsrWidth;
	logic clk, reset_n, tck, tms, tdi, tdo, tdoOe, extestActive, readBusOe;
	logic o, oe;
	logic [W-1:0] pinValues, pinDrive, pat, pre;
	logic [127:0] d;
	int bad_count = 0;
	int compares = 0;
	always #12.5 clk = ~clk;
	sram_boundary_scan_tap #(.IdCode(IdVal)) sram_boundary_scan_tap_inst (
		.clk(clk), .reset_n(reset_n), .tck(tck), .tms(tms), .tdi(tdi),
		.tdo(tdo), .tdoOe(tdoOe), .pinValues(pinValues),
		.pinDrive(pinDrive), .extestActive(extestActive),
		.readBusOe(readBusOe));
	scan_host scan_host_inst (.clk(clk), .tck(tck), .tms(tms), .tdi(tdi),
		.tdo(tdo), .tdoOe(tdoOe));
	task automatic chk(input logic [127:0] s, input logic [127:0] e);
		compares++;
		if (s !== e) begin
			bad_count++;
			$display("[FAIL] %0t seen %h want %h", $time, s, e);
		end
	endtask
	// Walks from idle through one instruction or data scan and back.
	task automatic scan(input bit ir, input int n, input logic [127:0] din);
		logic so, soe;
		d = '0;
		scan_host_inst.step(1'b1, 1'b1, so, soe);
		if (ir) begin
			scan_host_inst.step(1'b1, 1'b1, so, soe);
		end
		scan_host_inst.step(1'b0, 1'b1, so, soe);
		scan_host_inst.step(1'b0, 1'b1, so, soe);
		chk(soe, 1'b0);
		for (int i = 0; i < n; i++) begin
			scan_host_inst.step(i == n - 1, din[i], so, soe);
			d[i] = so;
			chk(soe, 1'b1);
		end
		scan_host_inst.step(1'b1, 1'b1, so, soe);
		scan_host_inst.step(1'b0, 1'b1, so, soe);
	endtask
	task automatic t_idcode();
		scan(1'b0, 32, '1);
		chk(d[31:0], IdVal);
	endtask
	task automatic t_bypass();
		logic [2:0] ops [4] = '{scan_tap_pkg::OpBypass, 3'h3, 3'h5, 3'h6};
		foreach (ops[k]) begin
			scan(1'b1, 3, ops[k]);
			chk(d[2:0], scan_tap_pkg::IrCapture);
			scan(1'b0, 4, 4'hb);
			chk(d[3:0], 4'h6);
		end
	endtask
	task automatic t_sample();
		pinValues <= pat;
		scan(1'b1, 3, scan_tap_pkg::OpSample);
		scan(1'b0, W, pre);
		chk(d[W-1:0], pat);
		chk(pinDrive, pre);
		chk(readBusOe, 1'b1);
	endtask
	task automatic t_float();
		scan(1'b1, 3, scan_tap_pkg::OpSampleZ);
		chk(readBusOe, 1'b0);
		chk(extestActive, 1'b0);
		scan(1'b1, 3, scan_tap_pkg::OpExtest);
		chk(extestActive, 1'b1);
		chk(pinDrive, pre);
		chk(readBusOe, 1'b0);
		scan_host_inst.reset5();
		chk(pinDrive[scan_tap_pkg::FloatCell], 1'b1);
		chk(readBusOe, 1'b1);
		t_idcode();
	endtask
	task automatic finish_test();
		if (bad_count == 0 && compares > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		reset_n = 1'b0;
		pinValues = '0;
		pat = W'({4{32'hc3a5_96e1}});
		pre = {1'b0, {4{27'h2b5_c9e3}}};
		repeat (6) @(posedge clk);
		reset_n <= 1'b1;
		repeat (3) @(posedge clk);
		chk(tdoOe, 1'b0);
		scan_host_inst.step(1'b0, 1'b1, o, oe);
		t_idcode();
		t_bypass();
		t_sample();
		t_float();
		finish_test();
	end
	initial begin
		#200us;
		bad_count++;
		finish_test();
	end
endmodule
`default_nettype wire
